// ### draw_pkg.sv
/*
  Constants for the figure drawing address engine: register offsets,
  figure type codes, command codes, presets and cycle phases.
  Assumes a byte-addressed register port with one word per register.
*/
// =====================================================================
// Operation
// [R1] Direction 7: add pitch, decrement if pointer MSB set, rotate left.
// [R2] Line pixels stay within the octant named by the start direction.
// [R3] Arc starts in given direction, curves, spans at most 45 degrees.
// [R4] DMA steps whole words; diagonals change both word coordinates.
// [R5] Host loads setup then draw-go; engine then draws the figure alone.
// [R6] Host stores up to 8x8 character; char-draw writes it from cursor.
// [R7] Character bits repeat horizontally and vertically by zoom 1 to 16.
// [R8] Parameter store is scanned to fill the requested height and width.
// [R9] Character bits taken snake-wise from location 15 bit 0 upwards.
// [R10] Narrow or short areas cut rows early; large areas tile pattern.
// [R11] Setup opcode presets count 0, first terms to 8, third term and mask ones.
// [R12] Host gives line count and error terms from axis deltas.
// [R13] Host gives arc count, radius terms and masked dots.
// [R14] Host gives rectangle count 3 and side terms.
// [R15] Host gives fill and character rows and row length.
// [R16] Host gives word access count minus one.
// [R17] Host gives DMA rows and bytes minus one.
// [R18] Engine runs one more read-modify-write cycle than the draw count.
// [R19] Arc drawing suppresses writes for the first masked-dot-count dots.
// [R20] All terms are binary, two's complement where signed.
// [R21] Unsent terms keep their preset values.
// [R22] Host may skip the two step terms when character size is 8.
// [R23] One pixel per four-clock cycle; next address computed meanwhile.
// [R24] Directions 0 to 7 start straight down, counterclockwise.
// [R25] Direction 0 adds pitch; right and left steps rotate the pointer.
// [R26] After the last cycle the engine idles and flags completion.
// =====================================================================
package draw_pkg;
  localparam int CUR_W_DEF = 18;
  localparam int CNT_W_DEF = 14;
  localparam int PITCH_W_DEF = 9;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_CNT = 8'h08;
  localparam logic [7:0] OFS_D = 8'h0C;
  localparam logic [7:0] OFS_TB = 8'h10;
  localparam logic [7:0] OFS_TC = 8'h14;
  localparam logic [7:0] OFS_MDC = 8'h18;
  localparam logic [7:0] OFS_CUR = 8'h1C;
  localparam logic [7:0] OFS_DOT = 8'h20;
  localparam logic [7:0] OFS_PITCH = 8'h24;
  localparam logic [7:0] OFS_ZOOM = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [1:0] PSTORE_SEL = 2'h1;
  // Control field positions
  localparam int CTRL_DIR_LSB = 0;
  localparam int CTRL_TYPE_LSB = 3;
  // Figure types
  localparam logic [2:0] FT_LINE = 3'h0;
  localparam logic [2:0] FT_ARC = 3'h1;
  localparam logic [2:0] FT_RECT = 3'h2;
  localparam logic [2:0] FT_FILL = 3'h3;
  localparam logic [2:0] FT_WORD_RD = 3'h4;
  localparam logic [2:0] FT_WORD_WR = 3'h5;
  localparam logic [2:0] FT_DMA_WR = 3'h6;
  localparam logic [2:0] FT_DMA_RD = 3'h7;
  // Commands
  localparam logic [1:0] CMD_SETUP = 2'h1;
  localparam logic [1:0] CMD_GO = 2'h2;
  localparam logic [1:0] CMD_CHAR = 2'h3;
  // Presets on the setup opcode
  localparam int PRESET_CNT = 0;
  localparam int PRESET_D = 8;
  // Store locations, cycle phases, direction offsets and engine states
  localparam logic [3:0] LIN_PAT_LO = 4'h8;
  localparam logic [3:0] LIN_PAT_HI = 4'h9;
  localparam logic [3:0] CHAR_TOP = 4'hF;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [2:0] DIR_PERP = 3'h2;
  localparam logic [2:0] DIR_REV = 3'h4;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DRAW = 2'b10
  } eng_state_e;
endpackage

// ### figure_draw_address_engine.sv
/*
  Figure drawing address engine: steps the word cursor and one-hot dot
  pointer through display memory, one four-clock modify cycle per pixel.
  Assumes an external mask/logic unit consumes the address, mask, pattern
  bit and write strobe, and a synchronous register master.
*/
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module figure_draw_address_engine #(
  parameter int CUR_W = draw_pkg::CUR_W_DEF,
  parameter int CNT_W = draw_pkg::CNT_W_DEF,
  parameter int PITCH_W = draw_pkg::PITCH_W_DEF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [draw_pkg::ADDR_W-1:0] addr_in,
  input wire logic [draw_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [draw_pkg::DATA_W-1:0] rdata_out,
  output logic [CUR_W-1:0] mem_addr_out,
  output logic [15:0] mem_mask_out,
  output logic mem_pattern_out,
  output logic mem_read_out,
  output logic mem_write_out,
  output logic busy_out,
  output logic done_out
);
  import draw_pkg::*;

  // =====================================================================
  // Register file
  logic [2:0] type_r, type_nxt, dirset_r, dirset_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, d_r, d_nxt, tb_r, tb_nxt;
  logic [CNT_W-1:0] tc_r, tc_nxt, mdc_r, mdc_nxt;
  logic [PITCH_W-1:0] pitch_r, pitch_nxt;
  logic [3:0] zoom_r, zoom_nxt;
  logic [7:0] ps_r [16];
  logic [7:0] ps_nxt [16];
  logic [DATA_W-1:0] rdata_nxt;
  logic wr_cmd, go_cmd;
  eng_state_e st_r, st_nxt;

  assign wr_cmd = wr_in && addr_in == OFS_CMD;
  // Start only from idle; a go during a figure is ignored
  assign go_cmd = wr_cmd && st_r == ST_IDLE &&
    (wdata_in[1:0] == CMD_GO || wdata_in[1:0] == CMD_CHAR); // [R5] [R6]

  // Parameter writes; setup opcode presets all terms
  always_comb begin
    type_nxt = type_r;
    dirset_nxt = dirset_r;
    cnt_nxt = cnt_r;
    d_nxt = d_r;
    tb_nxt = tb_r;
    tc_nxt = tc_r;
    mdc_nxt = mdc_r;
    pitch_nxt = pitch_r;
    zoom_nxt = zoom_r;
    ps_nxt = ps_r;
    if (wr_cmd && wdata_in[1:0] == CMD_SETUP) begin
      cnt_nxt = CNT_W'(PRESET_CNT); // [R11]
      d_nxt = CNT_W'(PRESET_D);
      tb_nxt = CNT_W'(PRESET_D);
      tc_nxt = '1; // [R11] unsent terms keep these [R21]
      mdc_nxt = '1;
    end else if (wr_in) begin
      unique case (addr_in)
        OFS_CTRL: begin
          dirset_nxt = wdata_in[CTRL_DIR_LSB +: 3];
          type_nxt = wdata_in[CTRL_TYPE_LSB +: 3];
        end
        OFS_CNT: cnt_nxt = wdata_in[CNT_W-1:0]; // Binary, two's compl. [R20]
        OFS_D: d_nxt = wdata_in[CNT_W-1:0];
        OFS_TB: tb_nxt = wdata_in[CNT_W-1:0];
        OFS_TC: tc_nxt = wdata_in[CNT_W-1:0];
        OFS_MDC: mdc_nxt = wdata_in[CNT_W-1:0];
        OFS_PITCH: pitch_nxt = wdata_in[PITCH_W-1:0];
        OFS_ZOOM: zoom_nxt = wdata_in[3:0];
        default: if (addr_in[7:6] == PSTORE_SEL)
          ps_nxt[addr_in[5:2]] = wdata_in[7:0]; // Character store [R6]
      endcase
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_nxt = '0;
    if (rd_in) begin
      unique case (addr_in)
        OFS_CTRL: rdata_nxt = DATA_W'({type_r, dirset_r});
        OFS_CNT: rdata_nxt = DATA_W'(cnt_r);
        OFS_D: rdata_nxt = DATA_W'(d_r);
        OFS_TB: rdata_nxt = DATA_W'(tb_r);
        OFS_TC: rdata_nxt = DATA_W'(tc_r);
        OFS_MDC: rdata_nxt = DATA_W'(mdc_r);
        OFS_CUR: rdata_nxt = DATA_W'(mem_addr_out);
        OFS_DOT: rdata_nxt = DATA_W'(mem_mask_out);
        OFS_PITCH: rdata_nxt = DATA_W'(pitch_r);
        OFS_ZOOM: rdata_nxt = DATA_W'(zoom_r);
        OFS_STATUS: rdata_nxt = DATA_W'({done_out, busy_out}); // [R26]
        default: if (addr_in[7:6] == PSTORE_SEL)
          rdata_nxt = DATA_W'(ps_r[addr_in[5:2]]);
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      type_r <= FT_LINE;
      dirset_r <= '0;
      cnt_r <= CNT_W'(PRESET_CNT);
      d_r <= CNT_W'(PRESET_D);
      tb_r <= CNT_W'(PRESET_D);
      tc_r <= '1;
      mdc_r <= '1;
      pitch_r <= '0;
      zoom_r <= '0;
      ps_r <= '{default: '0};
      rdata_out <= '0;
    end else begin
      type_r <= type_nxt;
      dirset_r <= dirset_nxt;
      cnt_r <= cnt_nxt;
      d_r <= d_nxt;
      tb_r <= tb_nxt;
      tc_r <= tc_nxt;
      mdc_r <= mdc_nxt;
      pitch_r <= pitch_nxt;
      zoom_r <= zoom_nxt;
      ps_r <= ps_nxt;
      rdata_out <= rdata_nxt;
    end
  end

  // =====================================================================
  // Address stepping: direction 0 is straight down, counterclockwise
  function automatic logic [CUR_W+15:0] step_addr(input logic [2:0] dir,
      input logic [CUR_W-1:0] cur, input logic [15:0] dot,
      input logic [PITCH_W-1:0] pitch, input logic word);
    logic [CUR_W-1:0] c;
    logic [15:0] p;
    c = cur;
    p = dot;
    if (dir == 3'h0 || dir == 3'h1 || dir == 3'h7)
      c = c + CUR_W'(pitch); // [R24] [R25] [R1]
    if (dir == 3'h3 || dir == 3'h4 || dir == 3'h5)
      c = c - CUR_W'(pitch);
    // Word walks move a whole word sideways on every sideways step [R4]
    if (dir == 3'h1 || dir == 3'h2 || dir == 3'h3) begin
      if (word || p[0])
        c = c + CUR_W'(1); // [R25]
      if (!word)
        p = {p[0], p[15:1]};
    end
    if (dir == 3'h5 || dir == 3'h6 || dir == 3'h7) begin
      if (word || p[15])
        c = c - CUR_W'(1); // [R1]
      if (!word)
        p = {p[14:0], p[15]};
    end
    return {c, p};
  endfunction

  // =====================================================================
  // Drawing engine
  logic [1:0] ph_r, ph_nxt;
  logic [CUR_W-1:0] cur_r, cur_nxt;
  logic [15:0] dot_r, dot_nxt;
  logic [2:0] dir_r, dir_nxt, perp_r, perp_nxt, sdir;
  logic signed [CNT_W-1:0] err_r, err_nxt, b_r, b_nxt, acc_r, acc_nxt;
  logic [CNT_W-1:0] alen_r, alen_nxt, dcnt_r, dcnt_nxt, mcnt_r, mcnt_nxt;
  logic [3:0] pidx_r, pidx_nxt, hz_r, hz_nxt, vz_r, vz_nxt;
  logic [2:0] col_r, col_nxt, prow_r, prow_nxt;
  logic side_r, side_nxt, colup_r, colup_nxt, chr_r, chr_nxt;
  logic done_r, done_nxt, pat_nxt, word, wr_ok, last, mask_dot, tiled;
  logic [CUR_W+15:0] stp;

  assign word = type_r == FT_WORD_RD || type_r == FT_WORD_WR ||
    type_r == FT_DMA_WR || type_r == FT_DMA_RD;
  assign tiled = chr_r || type_r == FT_FILL || type_r == FT_DMA_WR ||
    type_r == FT_DMA_RD;
  assign wr_ok = type_r != FT_WORD_RD && type_r != FT_DMA_RD;
  assign last = st_r == ST_DRAW && ph_r == PH_LAST;
  assign mask_dot = type_r == FT_ARC && mcnt_r != '0; // [R19]
  // Line steps in direction plus one on a non-negative error; arc on negative
  always_comb begin
    sdir = dir_r;
    if (type_r == FT_LINE && !err_r[CNT_W-1])
      sdir = dir_r + 3'h1; // [R2]
    if (type_r == FT_ARC && err_r[CNT_W-1])
      sdir = dir_r + 3'h1; // [R3]
  end
  assign stp = step_addr(sdir, cur_r, dot_r, pitch_r, word);

  // Next pixel is worked out during the current four-clock cycle [R23]
  always_comb begin
    st_nxt = st_r;
    ph_nxt = ph_r;
    cur_nxt = cur_r;
    dot_nxt = dot_r;
    dir_nxt = dir_r;
    perp_nxt = perp_r;
    err_nxt = err_r;
    b_nxt = b_r;
    acc_nxt = acc_r;
    alen_nxt = alen_r;
    dcnt_nxt = dcnt_r;
    mcnt_nxt = mcnt_r;
    pidx_nxt = pidx_r;
    hz_nxt = hz_r;
    vz_nxt = vz_r;
    col_nxt = col_r;
    prow_nxt = prow_r;
    side_nxt = side_r;
    colup_nxt = colup_r;
    chr_nxt = chr_r;
    done_nxt = done_r;
    // Pattern bit: snake through the store for tiles, else 16-bit dash [R9]
    if (tiled)
      pat_nxt = ps_r[CHAR_TOP - 4'(prow_r)][col_r];
    else
      pat_nxt = pidx_r[3] ? ps_r[LIN_PAT_HI][pidx_r[2:0]] :
        ps_r[LIN_PAT_LO][pidx_r[2:0]];
    unique case (st_r)
      ST_IDLE: begin
        if (wr_in && addr_in == OFS_CUR)
          cur_nxt = wdata_in[CUR_W-1:0];
        if (wr_in && addr_in == OFS_DOT)
          dot_nxt = 16'h0001 << wdata_in[3:0];
        if (go_cmd) begin
          st_nxt = ST_DRAW; // [R5]
          chr_nxt = wdata_in[1:0] == CMD_CHAR;
          ph_nxt = '0;
          dir_nxt = dirset_r;
          perp_nxt = dirset_r + DIR_PERP;
          err_nxt = d_r;
          b_nxt = tb_r;
          acc_nxt = CNT_W'(1);
          mcnt_nxt = mdc_r;
          {pidx_nxt, hz_nxt, vz_nxt} = '0;
          {col_nxt, prow_nxt, side_nxt} = '0;
          colup_nxt = 1'b1;
          done_nxt = 1'b0;
          dcnt_nxt = cnt_r; // Rows or sides
          unique case (type_r)
            FT_LINE, FT_ARC, FT_WORD_RD, FT_WORD_WR: begin
              alen_nxt = cnt_r; // One more cycle than the count [R18]
              dcnt_nxt = '0;
            end
            FT_RECT: alen_nxt = d_r;
            FT_FILL: alen_nxt = d_r - CNT_W'(1); // [R8]
            default: alen_nxt = d_r >> 1; // Two bytes per word
          endcase
        end
      end
      ST_DRAW: begin
        ph_nxt = ph_r + 2'h1; // [R23]
        if (last) begin
          pidx_nxt = pidx_r + 4'h1;
          if (mcnt_r != '0)
            mcnt_nxt = mcnt_r - CNT_W'(1); // [R19]
          if (type_r == FT_LINE)
            err_nxt = err_r + (err_r[CNT_W-1] ? tc_r : tb_r); // [R2]
          if (type_r == FT_ARC) begin
            acc_nxt = acc_r + CNT_W'(2);
            err_nxt = err_r - acc_r + (err_r[CNT_W-1] ? b_r : '0); // [R3]
            if (err_r[CNT_W-1])
              b_nxt = b_r - CNT_W'(2);
          end
          // Horizontal zoom: hold a bit for zoom+1 pixels [R7]
          hz_nxt = (hz_r == zoom_r || !chr_r) ? 4'h0 : hz_r + 4'h1;
          if (hz_nxt == 4'h0)
            col_nxt = colup_r ? col_r + 3'h1 : col_r - 3'h1; // [R9] [R10]
          if (alen_r != '0) begin
            alen_nxt = alen_r - CNT_W'(1);
            {cur_nxt, dot_nxt} = stp;
          end else if (dcnt_r != '0) begin
            dcnt_nxt = dcnt_r - CNT_W'(1);
            if (type_r == FT_RECT) begin
              dir_nxt = dir_r + DIR_PERP;
              side_nxt = !side_r;
              alen_nxt = side_r ? d_r - CNT_W'(1) : tb_r - CNT_W'(1);
              {cur_nxt, dot_nxt} = step_addr(dir_r + DIR_PERP, cur_r,
                dot_r, pitch_r, word);
            end else begin
              // Snake: step across, reverse, keep the same bit [R9] [R10]
              dir_nxt = dir_r + DIR_REV;
              alen_nxt = type_r == FT_FILL ? d_r - CNT_W'(1) : d_r >> 1;
              colup_nxt = !colup_r;
              col_nxt = col_r;
              hz_nxt = '0;
              vz_nxt = (vz_r == zoom_r || !chr_r) ? 4'h0 : vz_r + 4'h1;
              if (vz_nxt == 4'h0)
                prow_nxt = prow_r + 3'h1; // Wraps to tile rows [R10] [R7]
              {cur_nxt, dot_nxt} = step_addr(perp_r, cur_r, dot_r, pitch_r,
                word);
            end
          end else begin
            st_nxt = ST_IDLE; // [R26]
            done_nxt = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= ST_IDLE;
      {ph_r, cur_r, dot_r, dir_r, perp_r} <= '0;
      {err_r, b_r, acc_r, alen_r, dcnt_r, mcnt_r} <= '0;
      {pidx_r, hz_r, vz_r, col_r, prow_r} <= '0;
      {side_r, colup_r, chr_r, done_r, mem_pattern_out} <= '0;
    end else begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      cur_r <= cur_nxt;
      dot_r <= dot_nxt;
      dir_r <= dir_nxt;
      perp_r <= perp_nxt;
      err_r <= err_nxt;
      b_r <= b_nxt;
      acc_r <= acc_nxt;
      alen_r <= alen_nxt;
      dcnt_r <= dcnt_nxt;
      mcnt_r <= mcnt_nxt;
      pidx_r <= pidx_nxt;
      hz_r <= hz_nxt;
      vz_r <= vz_nxt;
      col_r <= col_nxt;
      prow_r <= prow_nxt;
      side_r <= side_nxt;
      colup_r <= colup_nxt;
      chr_r <= chr_nxt;
      done_r <= done_nxt;
      mem_pattern_out <= pat_nxt;
    end
  end

  // Memory strobes and status
  assign mem_addr_out = cur_r;
  assign mem_mask_out = dot_r;
  assign mem_read_out = st_r == ST_DRAW && ph_r == PH_READ;
  assign mem_write_out = last && wr_ok && !mask_dot; // [R19]
  assign busy_out = st_r == ST_DRAW;
  assign done_out = done_r;

  // =====================================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [CNT_W:0] seen_r;
  always_ff @(posedge clk_in) begin
    if (rst_in || go_cmd)
      seen_r <= '0;
    else if (last)
      seen_r <= seen_r + (CNT_W+1)'(1);
  end
  sequence s_modify;
    ph_r == 2'h1 ##1 ph_r == 2'h2 ##1 ph_r == 2'h3;
  endsequence
  a_modify_four_clocks: assert property ( // [R23]
    busy_out && ph_r == 2'h0 |=> s_modify) else $error("cycle not 4 clocks");
  a_setup_presets: assert property ( // [R11]
    wr_cmd && wdata_in[1:0] == CMD_SETUP |=> cnt_r == '0 &&
    d_r == CNT_W'(PRESET_D) && tb_r == CNT_W'(PRESET_D) && &tc_r && &mdc_r)
    else $error("setup presets wrong");
  a_go_starts: assert property ( // [R5]
    go_cmd |=> busy_out && ph_r == 2'h0) else $error("go not taken");
  a_dir7_step: assert property ( // [R1]
    last && type_r == FT_FILL && dir_r == 3'h7 && alen_r != '0 && dot_r[15]
    |=> cur_r == $past(cur_r) + CUR_W'(pitch_r) - CUR_W'(1) &&
    dot_r == 16'h0001) else $error("dir 7 step wrong");
  a_dir0_step: assert property ( // [R25]
    last && type_r == FT_FILL && dir_r == 3'h0 && alen_r != '0
    |=> cur_r == $past(cur_r) + CUR_W'(pitch_r) && $stable(dot_r))
    else $error("dir 0 step wrong");
  a_dma_diag: assert property ( // [R4]
    last && type_r == FT_DMA_WR && dir_r == 3'h1 && alen_r != '0
    |=> cur_r == $past(cur_r) + CUR_W'(pitch_r) + CUR_W'(1))
    else $error("word diagonal wrong");
  a_cycle_count: assert property ( // [R18]
    last && type_r == FT_LINE && st_nxt == ST_IDLE
    |-> seen_r == (CNT_W+1)'(cnt_r)) else $error("cycle count wrong");
  a_arc_masked: assert property ( // [R19]
    busy_out && type_r == FT_ARC && mcnt_r != '0 |-> !mem_write_out)
    else $error("masked dot written");
  a_done_idle: assert property ( // [R26]
    last && st_nxt == ST_IDLE |=> !busy_out && done_out [*2])
    else $error("no completion");
  a_zoom_hold: assert property ( // [R7]
    last && chr_r && alen_r != '0 && hz_r != zoom_r |=> $stable(col_r))
    else $error("zoom bit not held");
endmodule

// ### display_memory_model.sv
/*
  Display memory model for the figure drawing address engine: logs the
  read and write strobes of each figure with address and mask, and the pattern of each write.
  Assumes four-clock modify cycles, with the write two clocks after the
  read at the same word, and busy high across a figure.
*/
`timescale 1ns/100ps
module display_memory_model #(
  parameter int AW = 18
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [AW-1:0] mem_addr_in,
  input wire logic [15:0] mem_mask_in,
  input wire logic mem_pattern_in,
  input wire logic mem_read_in,
  input wire logic mem_write_in,
  input wire logic busy_in
);
  // ==================================================================
  // Strobe log
  logic [AW-1:0] rd_addr [0:63];
  logic [15:0] rd_mask [0:63];
  logic [AW-1:0] wr_addr [0:63];
  logic [15:0] wr_mask [0:63];
  logic wr_pat [0:63];
  logic [AW-1:0] addr_q = '0;
  logic busy_q = 1'b0;
  int n_rd = 0;
  int n_wr = 0;
  int n_phase_err = 0;
  int since_rd = 99;
  // Values are taken before the edge's updates land, as real memory would
  always @(posedge clk_in) begin
    if (rst_in || (busy_in && !busy_q)) begin
      n_rd = 0;
      n_wr = 0;
    end
    busy_q = busy_in;
    // Age the read counter first so both checks count edges since the read
    if (since_rd < 99) since_rd++;
    if (mem_write_in) begin
      // Write must close the cycle opened by the read
      if (since_rd != 2 || mem_addr_in !== addr_q) n_phase_err++;
      wr_addr[n_wr] = mem_addr_in;
      wr_mask[n_wr] = mem_mask_in;
      wr_pat[n_wr] = mem_pattern_in;
      n_wr++;
    end
    if (mem_read_in) begin
      // Reads of one figure come every four clocks, no gap
      if (n_rd > 0 && since_rd != 4) n_phase_err++;
      rd_addr[n_rd] = mem_addr_in;
      rd_mask[n_rd] = mem_mask_in;
      addr_q = mem_addr_in;
      n_rd++;
      since_rd = 0;
    end
  end
endmodule

// ### figure_draw_address_engine_tb.sv
/*
  Self-checking bench for the figure drawing address engine.
  Assumes draw_pkg and display_memory_model are compiled before it.
*/
`timescale 1ns/100ps
module figure_draw_address_engine_tb;
  import draw_pkg::*;
  localparam int P = 32;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wdata_in = '0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [DATA_W-1:0] rdata_out;
  logic [17:0] mem_addr_out;
  logic [15:0] mem_mask_out;
  logic mem_pattern_out, mem_read_out, mem_write_out, busy_out, done_out;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [33:0] e;
  logic [7:0] offs [5] = '{OFS_CNT, OFS_D, OFS_TB, OFS_TC, OFS_MDC};
  logic [31:0] pre [5] = '{0, 8, 8, 32'h0000_3FFF, 32'h0000_3FFF};
  int dots [3] = '{0, 15, 5};
  logic [2:0] typ [4] = '{FT_WORD_WR, FT_WORD_RD, FT_DMA_WR, FT_DMA_RD};

  always #2.5 clk_in = ~clk_in;

  figure_draw_address_engine figure_draw_address_engine_i (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .mem_addr_out(mem_addr_out),
    .mem_mask_out(mem_mask_out), .mem_pattern_out(mem_pattern_out),
    .mem_read_out(mem_read_out), .mem_write_out(mem_write_out),
    .busy_out(busy_out), .done_out(done_out));
  display_memory_model display_memory_model_i (
    .clk_in(clk_in), .rst_in(rst_in), .mem_addr_in(mem_addr_out),
    .mem_mask_in(mem_mask_out), .mem_pattern_in(mem_pattern_out),
    .mem_read_in(mem_read_out), .mem_write_in(mem_write_out),
    .busy_in(busy_out));

  // ==================================================================
  // Register port tasks; strobes change just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask
  // Setup opcode first so unsent terms fall back to the presets
  task automatic prep(input logic [2:0] t, input logic [2:0] dr,
                      input int cur, input int dot);
    wr(OFS_CMD, 32'(CMD_SETUP));
    wr(OFS_CTRL, 32'({t, dr}));
    wr(OFS_CUR, 32'(cur));
    wr(OFS_DOT, 32'(dot));
  endtask
  // The cursor poke lands while busy and must be ignored
  task automatic go(input logic [1:0] c);
    int k = 0;
    wr(OFS_CMD, 32'(c));
    wr(OFS_CUR, 32'h0000_0000);
    #1;
    while (busy_out !== 1'b0 && k < 300) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    chk(32'(done_out), 32'h0000_0001);
    chk(32'(display_memory_model_i.n_phase_err), 0);
  endtask
  // Expected next word cursor and dot pointer for one step
  function automatic logic [33:0] nxt(input logic [2:0] dr,
      input logic [17:0] c, input logic [15:0] m);
    logic [17:0] a;
    logic [15:0] k;
    a = c;
    k = m;
    if (dr inside {0, 1, 7}) a = a + P;
    if (dr inside {3, 4, 5}) a = a - P;
    if (dr inside {1, 2, 3}) begin
      if (m[0]) a = a + 1;
      k = {m[0], m[15:1]};
    end
    if (dr inside {5, 6, 7}) begin
      if (m[15]) a = a - 1;
      k = {m[14:0], m[15]};
    end
    return {a, k};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard, well above the thousand or so cycles the tests need
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("ERROR at %0t: run timed out", $time);
      give_verdict();
    end
  end

  // ==================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 5; i++) rchk(offs[i], pre[i]);
    rchk(OFS_STATUS, 0);
    rchk(8'h3C, 0);
    for (int i = 0; i < 5; i++) wr(offs[i], 32'h0000_0005);
    wr(OFS_CMD, 32'(CMD_SETUP));
    for (int i = 0; i < 5; i++) rchk(offs[i], pre[i]);
    wr(OFS_PITCH, P);
    // Two-pixel lines in every direction, pointer at LSB, MSB and middle
    for (int i = 0; i < 24; i++) begin
      prep(FT_LINE, 3'(i % 8), 32'h0000_0100, dots[i / 8]);
      wr(OFS_CNT, 1);
      wr(OFS_D, 32'h0000_3FFF);
      wr(OFS_TB, 32'h0000_3FFE);
      wr(OFS_TC, 0);
      go(CMD_GO);
      e = nxt(3'(i % 8), 18'h100, 16'h0001 << dots[i / 8]);
      chk(32'(display_memory_model_i.n_wr), 2);
      chk(32'(display_memory_model_i.wr_addr[1]), 32'(e[33:16]));
      chk(32'(display_memory_model_i.wr_mask[1]), 32'(e[15:0]));
    end
    rchk(OFS_STATUS, 32'h0000_0002);
    // Line of six steps with three diagonals, then an arc
    for (int f = 0; f < 2; f++) begin
      prep(f ? FT_ARC : FT_LINE, 3'h0, 32'h0000_0200, 8);
      wr(OFS_CNT, 6);
      wr(OFS_D, f ? 7 : 0);
      wr(OFS_TB, f ? 14 : 32'h0000_3FFA);
      wr(OFS_TC, f ? 32'h0000_3FFF : 6);
      if (f) wr(OFS_MDC, 2);
      go(CMD_GO);
      chk(32'(display_memory_model_i.n_rd), 7);
      chk(32'(display_memory_model_i.n_wr), f ? 5 : 7);
      for (int k = 1; k < 7; k++) begin
        chk(32'(display_memory_model_i.rd_addr[k]), 32'h200 + k * P);
        chk(32'(display_memory_model_i.rd_mask[k] <=
                display_memory_model_i.rd_mask[k - 1]), 1);
      end
      // The line's three diagonals end three pixels to the right
      if (f == 0)
        chk(32'(display_memory_model_i.rd_mask[6]), 32'h0000_0020);
    end
    chk(32'(display_memory_model_i.wr_addr[0]), 32'h200 + 2 * P);
    // Rectangle: first side is D+1 pixels, then the corner turns
    prep(FT_RECT, 3'h0, 32'h0000_0200, 8);
    wr(OFS_CNT, 3);
    wr(OFS_D, 2);
    wr(OFS_TB, 1);
    wr(OFS_MDC, 2);
    go(CMD_GO);
    chk(32'(display_memory_model_i.wr_addr[2]), 32'h200 + 2 * P);
    chk(32'(display_memory_model_i.wr_addr[3]), 32'h200 + 2 * P);
    chk(32'(display_memory_model_i.wr_mask[3]), 32'h0000_0080);
    // Character 3 wide, 2 high: snake through locations 15 and 14
    wr(8'h7C, 32'h0000_0005);
    wr(8'h78, 32'h0000_0006);
    prep(FT_FILL, 3'h0, 32'h0000_0200, 8);
    wr(OFS_ZOOM, 0);
    wr(OFS_CNT, 1);
    wr(OFS_D, 3);
    wr(OFS_TB, 3);
    go(CMD_CHAR);
    chk(32'(display_memory_model_i.n_wr), 6);
    for (int k = 0; k < 6; k++) begin
      chk(32'(display_memory_model_i.wr_pat[k]), 32'(k != 1 && k != 5));
    end
    chk(32'(display_memory_model_i.wr_addr[5]), 32'h0000_0200);
    chk(32'(display_memory_model_i.wr_mask[5]), 32'h0000_0080);
    // Full-width character on preset step terms, zoom 2, pointer at MSB
    prep(FT_FILL, 3'h7, 32'h0000_0200, 15);
    wr(OFS_ZOOM, 1);
    go(CMD_CHAR);
    chk(32'(display_memory_model_i.n_wr), 8);
    chk(32'(display_memory_model_i.wr_addr[1]), 32'h200 + P - 1);
    chk(32'(display_memory_model_i.wr_pat[1]), 1);
    chk(32'(display_memory_model_i.wr_pat[2]), 0);
    // Word and DMA walks: counts, read-only kinds and whole-word steps
    for (int i = 0; i < 4; i++) begin
      prep(typ[i], 3'h1, 32'h0000_0300, 8);
      wr(OFS_CNT, i < 2 ? 3 : 0);
      if (i > 1) wr(OFS_D, 3);
      if (i == 3) wr(OFS_TB, 1);
      go(CMD_GO);
      chk(32'(display_memory_model_i.n_rd), i < 2 ? 4 : 2);
      chk(32'(display_memory_model_i.n_wr), i == 0 ? 4 : i == 2 ? 2 : 0);
      if (i > 1) begin
        chk(32'(display_memory_model_i.rd_addr[1]), 32'h300 + P + 1);
      end
    end
    // Reset in the middle of a figure
    wr(OFS_CNT, 20);
    wr(OFS_CMD, 32'(CMD_GO));
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    #1 chk(32'({done_out, busy_out}), 0);
    rchk(OFS_CNT, 0);
    give_verdict();
  end
endmodule
